/* File: src/tlp_defs.svh */
// Constants of the instrument-bus talker/listener port: bus command codes,
// terminator codes, characters and reset values.
// Assumes inclusion by the port module, the checker and the bench only.
`ifndef TLP_DEFS_SVH
`define TLP_DEFS_SVH

// Multiline bus commands, seven data bits with ATN asserted
`define TLP_CMD_GTL 7'h01
`define TLP_CMD_SDC 7'h04
`define TLP_CMD_PPC 7'h05
`define TLP_CMD_GET 7'h08
`define TLP_CMD_LLO 7'h11
`define TLP_CMD_DCL 7'h14
`define TLP_CMD_SPE 7'h18
`define TLP_CMD_SPD 7'h19
`define TLP_CMD_UNL 7'h3f
`define TLP_CMD_UNT 7'h5f
// Address group tags in bits 6:5 of a command byte
`define TLP_GRP_LISTEN 2'h1
`define TLP_GRP_TALK 2'h2

// Terminator selections
`define TLP_TERM_CRLF 3'h0
`define TLP_TERM_LFCR 3'h1
`define TLP_TERM_CR 3'h2
`define TLP_TERM_LF 3'h3
`define TLP_TERM_NONE 3'h4

// Characters
`define TLP_CHAR_CR 8'h0d
`define TLP_CHAR_LF 8'h0a
`define TLP_CHAR_STAR 8'h2a
`define TLP_CHAR_QMARK 8'h3f

// Status byte: request-service bit position and mask of report bits
`define TLP_RQS_BIT 6
`define TLP_REPORT_MASK 8'hbf

// Address limits and defaults
`define TLP_ADDR_MIN 6'h01
`define TLP_ADDR_MAX 6'h20
`define TLP_DEF_ADDR 6'h0c
`define TLP_DEF_TERM 3'h0
`define TLP_DEF_EOI 1'h1

`endif

/* File: src/tlp_pkg.sv */
// Types of the instrument-bus talker/listener port.
// Assumes the constants header sits beside it in src/.
package tlp_pkg;

  // Interface settings: terminator, EOI use and bus address (1..32)
  typedef struct packed {
    logic [2:0] term;
    logic eoi_en;
    logic [5:0] addr;
  } tlp_cfg_t;

  // One message byte with its end-of-message mark
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tlp_item_t;

  // Source handshake states, Gray along the loop
  typedef enum logic [1:0] {
    TK_IDLE = 2'h0,
    TK_RFD = 2'h1,
    TK_DAV = 2'h3,
    TK_REL = 2'h2
  } tlp_tk_state_t;

  // Acceptor handshake states
  typedef enum logic {
    AC_IDLE = 1'h0,
    AC_ACC = 1'h1
  } tlp_ac_state_t;

  // Which part of an outgoing message is next
  typedef enum logic [1:0] {
    PH_DATA = 2'h0,
    PH_T1 = 2'h1,
    PH_T2 = 2'h3
  } tlp_phase_t;

  // Kind of the byte now being sourced
  typedef enum logic [1:0] {
    K_DATA = 2'h0,
    K_T1 = 2'h1,
    K_T2 = 2'h3,
    K_STAT = 2'h2
  } tlp_kind_t;

endpackage

/* File: src/tlp_port.sv */
// Device-side instrument-bus talker/listener port with its transmit FIFO.
// Assumes bus pins already synchronous to sys_clk and an outside wired-AND
// that resolves each open-drain line from the *_oe outputs (low while oe).
//
// Operation
// - Talker/listener only, never bus controller
// - No parallel poll; status by serial poll
// - Full acceptor and source three-wire handshakes
// - Group execute trigger ignored
// - Talker: basic, serial poll, talk-only; listen unaddresses
// - Listener: basic; talk address unaddresses listening
// - Holds terminator, EOI on/off, address 1-32
// - Defaults: CR LF, EOI on, address 12
// - REN asserted puts device in remote
// - IFC aborts transfers and addressed states
// - Assert SRQ to request service
// - Bytes under ATN decoded as commands
// - LLO locks out front panel
// - DCL clears interface activity to idle
// - Addressed commands need own listen address
// - SDC while addressed clears like DCL
// - GTL while addressed returns to local
// - SPE sends status byte; SPD stops
// - Leading asterisk marks common command
// - Common command ending in ? is query
// - SRQ only with enable bit 6 set
// - Serial poll read clears report bits
`timescale 1ns/10ps
`include "tlp_defs.svh"

// Synchronous FIFO, registered not-full flag, flush drops all entries
module tlp_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage array
  logic [AW-1:0] wr_reg; // Write pointer
  logic [AW-1:0] rd_reg; // Read pointer
  logic [AW:0] cnt_reg; // Entries held
  logic [AW:0] cnt_next;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];

  // Next occupancy
  always_comb begin
    cnt_next = cnt_reg;
    if (flush) begin
      cnt_next = '0;
    end else if (push && !pop) begin
      cnt_next = cnt_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - (AW+1)'(1);
    end
  end

  // Pointers, count and not-full flag
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(D - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(D - 1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != (AW+1)'(D));
    end
  end

  // Entry writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule

module tlp_port #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_defaults,
  input tlp_pkg::tlp_cfg_t cfg_in,
  output tlp_pkg::tlp_cfg_t cfg_out,
  input wire logic talk_only,
  input wire logic [7:0] status_set,
  input wire logic [7:0] sre,
  input wire logic tx_valid,
  input tlp_pkg::tlp_item_t tx_item,
  output logic tx_ready,
  output logic rx_valid,
  output tlp_pkg::tlp_item_t rx_item,
  input wire logic rx_ready,
  output logic rx_common,
  output logic rx_query,
  output logic remote,
  output logic lockout,
  output logic dev_clear,
  output logic listen_addr,
  output logic talk_addr,
  output logic serial_poll,
  input wire logic [7:0] dio_n_in,
  output logic [7:0] dio_n_out,
  output logic [7:0] dio_n_oe,
  input wire logic dav_n_in,
  output logic dav_n_out,
  output logic dav_n_oe,
  input wire logic nrfd_n_in,
  output logic nrfd_n_out,
  output logic nrfd_n_oe,
  input wire logic ndac_n_in,
  output logic ndac_n_out,
  output logic ndac_n_oe,
  input wire logic eoi_n_in,
  output logic eoi_n_out,
  output logic eoi_n_oe,
  output logic srq_n_out,
  output logic srq_n_oe,
  input wire logic atn_n_in,
  input wire logic ren_n_in,
  input wire logic ifc_n_in
);
  import tlp_pkg::*;

  // Bus lines in true sense
  logic atn, ren, ifc, dav, nrfd, ndac, eoi_rx;
  logic [7:0] bus_byte; // Received data lines
  logic [6:0] cmd; // Command code under ATN
  tlp_ac_state_t ac_reg; // Acceptor state
  tlp_tk_state_t tk_reg; // Source state
  tlp_phase_t ph_reg; // Message part pending
  tlp_kind_t kind_reg; // Kind of byte on the lines
  logic lad_reg, tad_reg, spe_reg; // Addressed and poll states
  logic ren_prev_reg; // REN one cycle back
  logic [7:0] stb_reg; // Sticky report bits
  logic msg_start_reg, qmark_reg; // Parser history
  logic ac_active, take, cmd_take, clr_now, rx_valid_next;
  logic my_listen, my_talk, tk_ok, have, sel_eoi, accept, single;
  logic rqs;
  logic [7:0] sel_byte, term1, term2, status_byte;
  tlp_kind_t sel_kind;
  tlp_item_t head; // FIFO head
  logic head_valid;

  assign atn = ~atn_n_in;
  assign ren = ~ren_n_in;
  assign ifc = ~ifc_n_in;
  assign dav = ~dav_n_in;
  assign nrfd = ~nrfd_n_in;
  assign ndac = ~ndac_n_in;
  assign eoi_rx = ~eoi_n_in;
  assign bus_byte = ~dio_n_in;
  assign cmd = bus_byte[6:0];

  // Acceptor joins under ATN or when addressed to listen
  assign ac_active = atn | lad_reg;
  assign take = (ac_reg == AC_IDLE) && ac_active && dav && !ifc
    && (atn || !rx_valid);
  assign cmd_take = take & atn;
  assign my_listen = (cmd == {`TLP_GRP_LISTEN, cfg_out.addr[4:0]});
  assign my_talk = (cmd == {`TLP_GRP_TALK, cfg_out.addr[4:0]});
  // Device clear: universal, or selective when listen addressed
  assign clr_now = cmd_take && ((cmd == `TLP_CMD_DCL)
    || ((cmd == `TLP_CMD_SDC) && lad_reg));

  // Next rx_valid, for the ready line
  always_comb begin
    rx_valid_next = rx_valid;
    if (ifc || clr_now) begin
      rx_valid_next = 1'b0;
    end else if (take && !atn) begin
      rx_valid_next = 1'b1;
    end else if (rx_ready) begin
      rx_valid_next = 1'b0;
    end
  end

  // Settings, loaded from defaults or a valid write
  always_ff @(posedge sys_clk) begin
    if (!rst_n || cfg_defaults) begin
      cfg_out <= '{term: `TLP_DEF_TERM, eoi_en: `TLP_DEF_EOI, addr: `TLP_DEF_ADDR};
    end else if (cfg_wr && cfg_in.addr >= `TLP_ADDR_MIN && cfg_in.addr <= `TLP_ADDR_MAX
        && cfg_in.term <= `TLP_TERM_NONE) begin
      cfg_out <= cfg_in;
    end
  end

  // Acceptor handshake and its line drives
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifc) begin
      ac_reg <= AC_IDLE;
      nrfd_n_oe <= 1'b0;
      ndac_n_oe <= 1'b0;
    end else begin
      case (ac_reg)
        AC_IDLE: begin
          // Byte latched
          if (take) begin
            ac_reg <= AC_ACC;
          end
        end
        AC_ACC: begin
          // Wait for the source to drop DAV
          if (!dav || !ac_active) begin
            ac_reg <= AC_IDLE;
          end
        end
        default: begin
          ac_reg <= AC_IDLE;
        end
      endcase
      nrfd_n_oe <= ac_active && (take || (ac_reg == AC_ACC && dav)
        || (!atn && rx_valid_next));
      ndac_n_oe <= ac_active && !take && !(ac_reg == AC_ACC && dav);
    end
  end

  // Addressing and serial poll mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifc) begin
      lad_reg <= 1'b0;
      tad_reg <= 1'b0;
      spe_reg <= 1'b0;
    end else if (cmd_take) begin
      if (my_listen) begin
        lad_reg <= 1'b1;
        tad_reg <= 1'b0;
      end else if (cmd == `TLP_CMD_UNL) begin
        lad_reg <= 1'b0;
      end else if (my_talk) begin
        tad_reg <= 1'b1;
        lad_reg <= 1'b0;
      end else if (cmd[6:5] == `TLP_GRP_TALK) begin
        tad_reg <= 1'b0; // Other talker or untalk
      end else if (lad_reg && cmd == `TLP_CMD_SPE) begin
        spe_reg <= 1'b1;
      end else if (lad_reg && cmd == `TLP_CMD_SPD) begin
        spe_reg <= 1'b0;
      end
      // Trigger, parallel poll: no action
    end
  end

  // Remote and lockout follow REN, GTL and LLO
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ren_prev_reg <= 1'b0;
      remote <= 1'b0;
      lockout <= 1'b0;
    end else begin
      ren_prev_reg <= ren;
      if (!ren) begin
        remote <= 1'b0;
        lockout <= 1'b0;
      end else if (cmd_take && cmd == `TLP_CMD_GTL && lad_reg) begin
        remote <= 1'b0;
      end else if (!ren_prev_reg || (cmd_take && my_listen)) begin
        remote <= 1'b1;
      end
      if (ren && cmd_take && cmd == `TLP_CMD_LLO) begin
        lockout <= 1'b1;
      end
    end
  end

  // Clear pulse and mirrored state outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dev_clear <= 1'b0;
      listen_addr <= 1'b0;
      talk_addr <= 1'b0;
      serial_poll <= 1'b0;
    end else begin
      dev_clear <= clr_now;
      listen_addr <= lad_reg;
      talk_addr <= tad_reg;
      serial_poll <= spe_reg;
    end
  end

  // Received data byte toward the user
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_item <= '0;
    end else begin
      rx_valid <= rx_valid_next;
      if (take && !atn) begin
        rx_item <= '{last: eoi_rx, data: bus_byte};
      end
    end
  end

  // Common command and query recognition on listened bytes
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifc || clr_now) begin
      msg_start_reg <= 1'b1;
      qmark_reg <= 1'b0;
      rx_common <= 1'b0;
      rx_query <= 1'b0;
    end else begin
      rx_query <= 1'b0;
      if (take && !atn) begin
        if (msg_start_reg) begin
          rx_common <= (bus_byte == `TLP_CHAR_STAR);
        end
        if (bus_byte == `TLP_CHAR_QMARK) begin
          qmark_reg <= 1'b1;
        end else if (bus_byte != `TLP_CHAR_CR && bus_byte != `TLP_CHAR_LF) begin
          qmark_reg <= 1'b0;
        end
        // Message ends on EOI or line feed
        if (eoi_rx || bus_byte == `TLP_CHAR_LF) begin
          msg_start_reg <= 1'b1;
          rx_query <= (msg_start_reg ? (bus_byte == `TLP_CHAR_STAR) : rx_common)
            && (bus_byte == `TLP_CHAR_QMARK || qmark_reg);
        end else begin
          msg_start_reg <= 1'b0;
        end
      end
    end
  end

  // Status byte with request-service summary
  assign rqs = sre[`TLP_RQS_BIT] && ((stb_reg & sre & `TLP_REPORT_MASK) != 8'h00);
  assign status_byte = {stb_reg[7], rqs, stb_reg[5:0]};

  // Report bits: new events win over the poll-read clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stb_reg <= 8'h00;
    end else begin
      stb_reg <= ((accept && kind_reg == K_STAT) ? 8'h00 : stb_reg)
        | (status_set & `TLP_REPORT_MASK);
    end
  end

  // Service request line
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      srq_n_oe <= 1'b0;
    end else begin
      srq_n_oe <= rqs;
    end
  end

  // Terminator characters and next outgoing byte
  assign single = (cfg_out.term == `TLP_TERM_CR) || (cfg_out.term == `TLP_TERM_LF);
  assign term1 = (cfg_out.term == `TLP_TERM_LFCR || cfg_out.term == `TLP_TERM_LF)
    ? `TLP_CHAR_LF : `TLP_CHAR_CR;
  assign term2 = (cfg_out.term == `TLP_TERM_CRLF) ? `TLP_CHAR_LF : `TLP_CHAR_CR;
  assign tk_ok = !atn && !ifc && (tad_reg || talk_only);

  always_comb begin
    have = 1'b1;
    sel_byte = status_byte;
    sel_kind = K_STAT;
    sel_eoi = 1'b0;
    if (spe_reg && tad_reg) begin
      sel_kind = K_STAT;
    end else if (ph_reg == PH_T1) begin
      sel_byte = term1;
      sel_kind = K_T1;
      sel_eoi = cfg_out.eoi_en && single;
    end else if (ph_reg == PH_T2) begin
      sel_byte = term2;
      sel_kind = K_T2;
      sel_eoi = cfg_out.eoi_en;
    end else begin
      have = head_valid;
      sel_byte = head.data;
      sel_kind = K_DATA;
      sel_eoi = cfg_out.eoi_en && head.last && (cfg_out.term == `TLP_TERM_NONE);
    end
  end

  // Byte taken by all acceptors
  assign accept = (tk_reg == TK_DAV) && tk_ok && !ndac;

  // Source handshake and its line drives
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifc || clr_now) begin
      tk_reg <= TK_IDLE;
      kind_reg <= K_DATA;
      dio_n_oe <= 8'h00;
      eoi_n_oe <= 1'b0;
      dav_n_oe <= 1'b0;
    end else begin
      case (tk_reg)
        TK_IDLE: begin
          if (tk_ok && have) begin
            tk_reg <= TK_RFD;
            kind_reg <= sel_kind;
            dio_n_oe <= sel_byte;
            eoi_n_oe <= sel_eoi;
          end
        end
        TK_RFD: begin
          // Data settled; wait until every acceptor is ready
          if (!tk_ok) begin
            tk_reg <= TK_IDLE;
          end else if (!nrfd) begin
            tk_reg <= TK_DAV;
            dav_n_oe <= 1'b1;
          end
        end
        TK_DAV: begin
          // Hold until accepted; ATN aborts, byte kept
          if (!tk_ok || !ndac) begin
            tk_reg <= tk_ok ? TK_REL : TK_IDLE;
            dav_n_oe <= 1'b0;
          end
        end
        TK_REL: begin
          tk_reg <= TK_IDLE;
        end
        default: begin
          tk_reg <= TK_IDLE;
        end
      endcase
      if (tk_reg != TK_IDLE && (!tk_ok || tk_reg == TK_REL)) begin
        dio_n_oe <= 8'h00;
        eoi_n_oe <= 1'b0;
      end
    end
  end

  // Message part sequencing after each accepted byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifc || clr_now) begin
      ph_reg <= PH_DATA;
    end else if (accept) begin
      case (kind_reg)
        K_DATA: ph_reg <= (head.last && cfg_out.term != `TLP_TERM_NONE) ? PH_T1 : PH_DATA;
        K_T1: ph_reg <= single ? PH_DATA : PH_T2;
        K_T2: ph_reg <= PH_DATA;
        default: ph_reg <= ph_reg;
      endcase
    end
  end

  // Open-drain lines only ever pull low
  always_ff @(posedge sys_clk) begin
    dio_n_out <= 8'h00;
    dav_n_out <= 1'b0;
    nrfd_n_out <= 1'b0;
    ndac_n_out <= 1'b0;
    eoi_n_out <= 1'b0;
    srq_n_out <= 1'b0;
  end

  // Outgoing message bytes
  tlp_fifo #(.W($bits(tlp_item_t)), .D(FIFO_DEPTH)) u_tx_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .flush(clr_now || ifc),
    .in_valid(tx_valid),
    .in_data(tx_item),
    .in_ready(tx_ready),
    .out_valid(head_valid),
    .out_data(head),
    .out_ready(accept && kind_reg == K_DATA)
  );
endmodule

/* File: testbench/tlp_port_properties.sv */
// Checker for the instrument-bus talker/listener port.
// Bound to tlp_port at the foot of this file; sees only the port's pins.
`timescale 1ns/10ps
`include "tlp_defs.svh"
module tlp_port_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_defaults,
  input tlp_pkg::tlp_cfg_t cfg_in,
  input tlp_pkg::tlp_cfg_t cfg_out,
  input wire logic talk_only,
  input wire logic [7:0] sre,
  input wire logic ren_n_in,
  input wire logic ifc_n_in,
  input wire logic nrfd_n_in,
  input wire logic remote,
  input wire logic lockout,
  input wire logic listen_addr,
  input wire logic talk_addr,
  input wire logic serial_poll,
  input wire logic dav_n_oe,
  input wire logic srq_n_oe
);
  import tlp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Settings within the legal ranges
  wire logic in_rng = cfg_in.addr >= `TLP_ADDR_MIN && cfg_in.addr <= `TLP_ADDR_MAX
    && cfg_in.term <= `TLP_TERM_NONE;
  // Settings write that the port must accept
  sequence s_good_wr;
    cfg_wr && !cfg_defaults && in_rng;
  endsequence
  // Settings write that is out of range
  sequence s_bad_wr;
    cfg_wr && !cfg_defaults && !in_rng;
  endsequence
  // Start of a sourced byte
  sequence s_dav_start;
    $rose(dav_n_oe);
  endsequence
  property p_cfg_load;
    s_good_wr |=> cfg_out == $past(cfg_in);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("settings not loaded");
  property p_cfg_keep;
    s_bad_wr |=> $stable(cfg_out);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("bad settings taken");
  property p_cfg_def;
    cfg_defaults |=> cfg_out == {`TLP_DEF_TERM, `TLP_DEF_EOI, `TLP_DEF_ADDR};
  endproperty
  a_cfg_def: assert property (p_cfg_def) else $error("defaults wrong");
  property p_remote_on;
    $fell(ren_n_in) |-> ##[1:2] remote;
  endproperty
  a_remote_on: assert property (p_remote_on) else $error("remote not entered");
  property p_remote_off;
    $rose(ren_n_in) |-> ##[1:2] (!remote && !lockout);
  endproperty
  a_remote_off: assert property (p_remote_off) else $error("remote kept");
  property p_ifc;
    !ifc_n_in |=> !dav_n_oe ##1 (!listen_addr && !talk_addr && !serial_poll);
  endproperty
  a_ifc: assert property (p_ifc) else $error("clear did not abort");
  property p_one_role;
    !(listen_addr && talk_addr);
  endproperty
  a_one_role: assert property (p_one_role) else $error("talk and listen both");
  property p_dav_rdy;
    s_dav_start |-> $past(nrfd_n_in) && $past(talk_addr || talk_only);
  endproperty
  a_dav_rdy: assert property (p_dav_rdy) else $error("byte sourced early");
  property p_srq;
    srq_n_oe |-> $past(sre[6]);
  endproperty
  a_srq: assert property (p_srq) else $error("request while disabled");
endmodule

bind tlp_port tlp_port_chk i_chk (.sys_clk, .rst_n, .cfg_wr, .cfg_defaults, .cfg_in, .cfg_out,
  .talk_only, .sre, .ren_n_in, .ifc_n_in, .nrfd_n_in, .remote, .lockout, .listen_addr,
  .talk_addr, .serial_poll, .dav_n_oe, .srq_n_oe);

/* File: testbench/tlp_ctrl_model.sv */
// Bus controller model: sources bytes and accepts the port's bytes.
// Assumes the bench resolves each line; a set *_oe pulls it low.
`timescale 1ns/10ps
module tlp_ctrl_model (
  input wire logic sys_clk,
  input wire logic [7:0] slow,
  input wire logic [7:0] dio_n,
  input wire logic dav_n,
  input wire logic nrfd_n,
  input wire logic ndac_n,
  input wire logic eoi_n,
  output logic [7:0] dio_oe,
  output logic dav_oe,
  output logic nrfd_oe,
  output logic ndac_oe,
  output logic eoi_oe
);
  int n_hang = 0; // Waits that ran out
  // Idle: lines released, not ready for data
  initial begin
    dio_oe = 8'h00;
    dav_oe = 1'b0;
    nrfd_oe = 1'b1;
    ndac_oe = 1'b0;
    eoi_oe = 1'b0;
  end
  // Bounded wait for line 0 NRFD, 1 NDAC, 2 DAV to reach a level
  task automatic wait_lvl(input int which, input logic lvl);
    int k;
    logic v;
    k = 0;
    do begin
      @(posedge sys_clk);
      v = (which == 0) ? nrfd_n : (which == 1) ? ndac_n : dav_n;
      k++;
    end while (v !== lvl && k < 500);
    if (v !== lvl) n_hang++;
  endtask
  // Source one byte through the three-wire interlock
  task automatic send(input logic [7:0] b, input logic e);
    nrfd_oe <= 1'b0;
    dio_oe <= b;
    eoi_oe <= e;
    wait_lvl(0, 1'b1);
    dav_oe <= 1'b1;
    wait_lvl(1, 1'b1);
    dav_oe <= 1'b0;
    @(posedge sys_clk);
    dio_oe <= 8'h00;
    eoi_oe <= 1'b0;
    nrfd_oe <= 1'b1;
    @(posedge sys_clk);
  endtask
  // Accept one byte, stalling slow edges twice
  task automatic recv(output logic [8:0] got);
    repeat (slow) @(posedge sys_clk);
    ndac_oe <= 1'b1;
    nrfd_oe <= 1'b0;
    wait_lvl(2, 1'b0);
    got = {~eoi_n, ~dio_n};
    nrfd_oe <= 1'b1;
    repeat (slow) @(posedge sys_clk);
    ndac_oe <= 1'b0;
    wait_lvl(2, 1'b1);
  endtask
endmodule

/* File: testbench/tlp_port_tb_top.sv */
// Bench of the talker/listener port against the controller model.
// Assumes pull-ups on all bus lines; parties only pull lines low.
`timescale 1ns/10ps
`include "tlp_defs.svh"
module tlp_port_tb_top;
  import tlp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n, cfg_wr, cfg_defaults, talk_only, tx_valid, rx_ready, ok;
  logic atn_n, ren_n, ifc_n, tx_ready, rx_valid, rx_common, rx_query;
  logic remote, lockout, dev_clear, listen_addr, talk_addr, serial_poll;
  logic d_dav, d_nrfd, d_ndac, d_eoi, srq_oe, c_dav, c_nrfd, c_ndac, c_eoi;
  logic [7:0] status_set, sre, d_dio, c_dio, slow;
  logic [8:0] got;
  tlp_cfg_t cfg_in, cfg_out;
  tlp_item_t tx_item, rx_item;
  tlp_item_t rxq[$]; // Items the listener handed over
  int n_mismatch = 0;
  int compares = 0;
  int nq = 0; // Query pulses
  int ndc = 0; // Device-clear pulses
  int n, n_ok;
  logic [8:0] exp_rx[4] = '{9'h02a, 9'h049, 9'h044, 9'h13f};
  logic [8:0] exp_tx[4] = '{9'h041, 9'h042, 9'h00d, 9'h10a};
  localparam tlp_cfg_t DEF = {`TLP_DEF_TERM, `TLP_DEF_EOI, `TLP_DEF_ADDR};
  localparam logic [6:0] MLA = {`TLP_GRP_LISTEN, 5'h0c};
  localparam logic [6:0] MTA = {`TLP_GRP_TALK, 5'h0c};
  // Wired-AND of both parties
  wire logic [7:0] dio_n = ~(d_dio | c_dio);
  wire logic dav_n = ~(d_dav | c_dav);
  wire logic nrfd_n = ~(d_nrfd | c_nrfd);
  wire logic ndac_n = ~(d_ndac | c_ndac);
  wire logic eoi_n = ~(d_eoi | c_eoi);
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  tlp_port #(.FIFO_DEPTH(16)) i_dut (.sys_clk, .rst_n, .cfg_wr, .cfg_defaults, .cfg_in,
    .cfg_out, .talk_only, .status_set, .sre, .tx_valid, .tx_item, .tx_ready, .rx_valid,
    .rx_item, .rx_ready, .rx_common, .rx_query, .remote, .lockout, .dev_clear, .listen_addr,
    .talk_addr, .serial_poll, .dio_n_in(dio_n), .dio_n_out(), .dio_n_oe(d_dio),
    .dav_n_in(dav_n), .dav_n_out(), .dav_n_oe(d_dav), .nrfd_n_in(nrfd_n), .nrfd_n_out(),
    .nrfd_n_oe(d_nrfd), .ndac_n_in(ndac_n), .ndac_n_out(), .ndac_n_oe(d_ndac),
    .eoi_n_in(eoi_n), .eoi_n_out(), .eoi_n_oe(d_eoi), .srq_n_out(), .srq_n_oe(srq_oe),
    .atn_n_in(atn_n), .ren_n_in(ren_n), .ifc_n_in(ifc_n));
  tlp_ctrl_model i_ctrl (.sys_clk, .slow, .dio_n, .dav_n, .nrfd_n, .ndac_n, .eoi_n,
    .dio_oe(c_dio), .dav_oe(c_dav), .nrfd_oe(c_nrfd), .ndac_oe(c_ndac), .eoi_oe(c_eoi));
  // Collects received items and event pulses
  always @(posedge sys_clk) begin
    if (rx_valid && rx_ready) rxq.push_back(rx_item);
    if (rx_query) nq++;
    if (dev_clear) ndc++;
  end
  // Compares one result
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Command byte with ATN asserted
  task automatic cmd(input logic [6:0] b);
    if (atn_n) begin
      atn_n <= 1'b0;
      @(posedge sys_clk);
    end
    i_ctrl.send({1'b0, b}, 1'b0);
    repeat (2) @(posedge sys_clk);
  endtask
  // Data byte, EOI in bit 8, ATN released
  task automatic data(input logic [8:0] b);
    if (!atn_n) begin
      atn_n <= 1'b1;
      @(posedge sys_clk);
    end
    i_ctrl.send(b[7:0], b[8]);
  endtask
  // Settings write or defaults pulse
  task automatic cfg(input logic w, input logic d, input tlp_cfg_t c);
    cfg_wr <= w;
    cfg_defaults <= d;
    cfg_in <= c;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_defaults <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Offers one FIFO item; refused after 8 edges
  task automatic push(input logic [8:0] i, output logic acc);
    tx_valid <= 1'b1;
    tx_item <= i;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 8);
    acc = tx_ready;
    tx_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Sets status bit 0 and lets the request settle
  task automatic stat_pulse;
    status_set <= 8'h01;
    @(posedge sys_clk);
    status_set <= 8'h00;
    repeat (3) @(posedge sys_clk);
  endtask
  // Verdict and end of run
  task automatic test_done;
    n_mismatch += i_ctrl.n_hang;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    test_done;
  end
  // Main sequence
  initial begin
    {rst_n, cfg_wr, cfg_defaults, talk_only, tx_valid} = 5'h00;
    {rx_ready, atn_n, ren_n, ifc_n} = 4'hf;
    {status_set, sre, slow} = 24'h000000;
    cfg_in = DEF;
    tx_item = 9'h000;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(cfg_out, DEF);
    chk({tx_ready, remote, srq_oe, d_dav, d_nrfd}, 16'h10);
    cfg(1'b1, 1'b0, {`TLP_TERM_LF, 1'b0, 6'h00});
    chk(cfg_out, DEF);
    cfg(1'b1, 1'b0, {`TLP_TERM_LF, 1'b0, 6'h21});
    cfg(1'b1, 1'b0, {3'h5, 1'b0, 6'h20});
    chk(cfg_out, DEF);
    cfg(1'b1, 1'b0, {`TLP_TERM_LF, 1'b0, 6'h20});
    chk(cfg_out, 16'h1a0);
    cfg(1'b1, 1'b1, {`TLP_TERM_LF, 1'b0, 6'h20});
    chk(cfg_out, DEF);
    ren_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(remote, 1'b1);
    cmd(`TLP_CMD_LLO);
    chk(lockout, 1'b1);
    cmd(`TLP_CMD_GTL);
    chk(remote, 1'b1);
    cmd(MLA);
    chk(listen_addr, 1'b1);
    cmd(`TLP_CMD_GTL);
    chk(remote, 1'b0);
    cmd(`TLP_CMD_GET);
    cmd(`TLP_CMD_DCL);
    chk(ndc[15:0], 16'h1);
    cmd(`TLP_CMD_SDC);
    chk(ndc[15:0], 16'h2);
    cmd(`TLP_CMD_UNL);
    cmd(`TLP_CMD_SDC);
    chk({ndc[14:0], listen_addr}, 16'h4);
    cmd(MLA);
    foreach (exp_rx[i]) data(exp_rx[i]);
    repeat (4) @(posedge sys_clk);
    chk(16'(rxq.size()), 16'h4);
    foreach (exp_rx[i]) chk(rxq[i], exp_rx[i]);
    chk({rx_common, nq[3:0]}, 16'h11);
    push({1'b0, 8'h41}, ok);
    push({1'b1, 8'h42}, ok);
    cmd(MTA);
    chk({listen_addr, talk_addr}, 16'h1);
    atn_n <= 1'b1;
    foreach (exp_tx[i]) begin
      i_ctrl.recv(got);
      chk(got, exp_tx[i]);
    end
    sre <= 8'h41;
    stat_pulse;
    chk(srq_oe, 1'b1);
    cmd(MLA);
    cmd(`TLP_CMD_SPE);
    cmd(MTA);
    chk(serial_poll, 1'b1);
    atn_n <= 1'b1;
    i_ctrl.recv(got);
    chk(got, 9'h041);
    repeat (3) @(posedge sys_clk);
    chk(srq_oe, 1'b0);
    cmd(MLA);
    cmd(`TLP_CMD_SPD);
    chk(serial_poll, 1'b0);
    sre <= 8'h01;
    stat_pulse;
    chk(srq_oe, 1'b0);
    ifc_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    ifc_n <= 1'b1;
    @(posedge sys_clk);
    chk({listen_addr, talk_addr, serial_poll}, 16'h0);
    // Fill FIFO past full, drain with a slow acceptor
    n_ok = 0;
    for (int i = 0; i < 17; i++) begin
      push({1'b0, 8'(i)}, ok);
      n_ok += int'(ok);
    end
    chk(n_ok[15:0], 16'h10);
    slow <= 8'h03;
    talk_only <= 1'b1;
    atn_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      i_ctrl.recv(got);
      chk(got, {1'b0, 8'(i)});
    end
    chk(tx_ready, 1'b1);
    talk_only <= 1'b0;
    ren_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({remote, lockout}, 16'h0);
    test_done;
  end
endmodule
